// File: rtl/sampling_clock_pkg.sv
// constants shared by the sampling clock and timestamp control block
// assumes a 40 MHz register clock and a 32-bit APB register bus
package sampling_clock_pkg;
	localparam int        SAMPLE_WIDTH      = 12;
	localparam int        DELAY_WIDTH       = 8;
	localparam int        SYNC_STAGES       = 2;
	localparam int        CORE_LATENCY      = 3;
	localparam int        FIFO_DEPTH        = 4;
	localparam int        CLK_FREQ_MHZ      = 40;

	// register byte offsets
	localparam logic [7:0] OFS_CLOCK_CONTROL_ONE = 8'h00;
	localparam logic [7:0] OFS_MARKER_CONTROL    = 8'h04;
	localparam logic [7:0] OFS_APERTURE_CONTROL  = 8'h08;
	localparam logic [7:0] OFS_FRAME_CONTROL     = 8'h0C;
	localparam logic [7:0] OFS_STATUS            = 8'h10;

	// clock_control_one fields
	localparam int BIT_REF_AS_MARKER   = 0;
	localparam int BIT_SINGLE_CHANNEL  = 1;
	// marker_control fields
	localparam int BIT_MARKER_INSERT   = 0;
	// aperture_control fields
	localparam int POS_COARSE          = 0;
	localparam int POS_FINE            = 8;
	localparam int BIT_INVERT          = 16;
	localparam int BIT_RAMP_EN         = 17;
	localparam int BIT_RAMP_FAST       = 18;
	// frame_control fields
	localparam int POS_DEMUX           = 0;
	localparam int POS_FRAME_LEN       = 8;
	// status fields
	localparam int POS_APPLIED_COARSE  = 0;
	localparam int BIT_RAMP_BUSY       = 8;
	localparam int BIT_REF_SEEN        = 9;

	// reset values
	localparam logic [3:0] RST_DEMUX      = 4'h0;
	localparam logic [7:0] RST_FRAME_LEN  = 8'h01;
	localparam logic [7:0] RST_DELAY      = 8'h00;

	// ramp timing in device clock cycles
	localparam int RAMP_PERIOD_CYCLES = 256;
	localparam int RAMP_SLOW_STEPS    = 1;
	localparam int RAMP_FAST_STEPS    = 4;
	localparam int RAMP_SLOW_INTERVAL = RAMP_PERIOD_CYCLES / RAMP_SLOW_STEPS;
	localparam int RAMP_FAST_INTERVAL = RAMP_PERIOD_CYCLES / RAMP_FAST_STEPS;

	typedef enum logic [1:0] {RAMP_IDLE, RAMP_UP, RAMP_DOWN} ramp_state_t;
endpackage : sampling_clock_pkg

// File: rtl/sample_fifo.sv
// small synchronous FIFO for the output sample path
// assumes one clock; full and empty flags come from flops
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic [AW:0]      count_nxt;
	logic             push;
	logic             pop;

	assign push     = clk_en && in_valid && in_ready;
	assign pop      = clk_en && out_valid && out_ready;
	assign out_data = mem[rd_ptr_r];

	always_comb
	begin
		count_nxt = count_r;
		if (push && !pop)
			count_nxt = count_r + 1'b1;
		else if (pop && !push)
			count_nxt = count_r - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_r] <= in_data;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr_r  <= '0;
			rd_ptr_r  <= '0;
			count_r   <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end
		else if (clk_en)
		begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			count_r   <= count_nxt;
			in_ready  <= (count_nxt != (AW+1)'(DEPTH));
			out_valid <= (count_nxt != '0);
		end
	end
endmodule : sample_fifo

// File: rtl/sampling_clock_timestamp_control.sv
// sampling clock, frame strobe, aperture delay and timestamp control
// assumes samples arrive on clk; marker and reference pins are asynchronous
//
// Summary of operation
// - insert marker only when insert enable set
// - marker enabled: upper 11 bits plus marker LSB
// - marker path latency equals sample path latency
// - async trigger sampled alongside the analog input
// - reference-as-marker bit selects reference as source
// - device clock drives sampling, processing, output
// - dual mode: one rising-edge sample per clock
// - single mode: sample on both clock edges
// - reference event resets dividers and strobe logic
// - invert bit delays clocking half a period
// - coarse, fine 256 settings each, combined additively
// - delay shifts all clocks including output timing; lvds_bus_clock follows only the invert bit, not coarse or fine
// - delay rewritable live without halting conversion
// - ramp: one or four coarse steps per 256
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
module sampling_clock_timestamp_control
	import sampling_clock_pkg::*;
#(
	parameter int SW  = SAMPLE_WIDTH,
	parameter int LAT = CORE_LATENCY,
	parameter int FD  = FIFO_DEPTH
) (
	input  wire logic          clk,
	input  wire logic          reset_n,
	input  wire logic          clk_en,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          sample_valid,
	output logic               sample_ready,
	input  wire logic [SW-1:0] ch_a_sample,
	input  wire logic [SW-1:0] ch_b_sample,
	input  wire logic          trigger_marker_input,
	input  wire logic          system_reference_pulse,
	input  wire logic          lvds_ready,
	output logic [2*SW-1:0]    lvds_bus_data,
	output logic               lvds_bus_strobe,
	output logic               lvds_bus_valid,
	output logic               lvds_bus_clock,
	output logic               sample_on_both_edges,
	output logic               half_period_clock_invert,
	output logic [7:0]         coarse_aperture_delay,
	output logic [7:0]         fine_aperture_delay
);
	localparam int PIPE = SYNC_STAGES + LAT;
	localparam int FW   = 2 * SW + 1;

	// register state
	logic        reference_as_marker_enable_r;
	logic        single_channel_r;
	logic        marker_insert_enable_r;
	logic [7:0]  coarse_target_r;
	logic [7:0]  fine_r;
	logic        invert_r;
	logic        aperture_delay_ramp_r;
	logic        ramp_speed_select_r;
	logic [3:0]  demux_factor_setting_r;
	logic [7:0]  frame_length_setting_r;
	logic        ref_seen_r;

	// apb decode
	logic        acc_first;
	logic        wr_take;
	logic        addr_ok;
	logic        wr_aperture;
	logic [31:0] rd_value;

	assign acc_first   = psel && penable && !pready;
	assign wr_take     = psel && penable && pready && pwrite && !pslverr;
	assign wr_aperture = wr_take && (paddr == OFS_APERTURE_CONTROL);
	assign addr_ok     = (paddr == OFS_CLOCK_CONTROL_ONE) || (paddr == OFS_MARKER_CONTROL)
		|| (paddr == OFS_APERTURE_CONTROL) || (paddr == OFS_FRAME_CONTROL)
		|| (paddr == OFS_STATUS);

	// pin synchronisers; first stage feeds only the second
	logic [SYNC_STAGES-1:0] trig_sync_r;
	logic [SYNC_STAGES-1:0] mref_sync_r;
	logic [SYNC_STAGES-1:0] ref_sync_r;
	logic                   ref_last_r;
	logic                   ref_event;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ref_sync_r  <= '0;
			ref_last_r  <= 1'b0;
		end
		else if (clk_en)
		begin
			ref_sync_r  <= {ref_sync_r[SYNC_STAGES-2:0], system_reference_pulse};
			ref_last_r  <= ref_sync_r[SYNC_STAGES-1];
		end
	end

	assign ref_event = ref_sync_r[SYNC_STAGES-1] && !ref_last_r;

	// ramp engine
	ramp_state_t ramp_state_r;
	logic [7:0]  applied_coarse_r;
	logic [7:0]  ramp_cnt_r;
	logic        ramp_tick;

	assign ramp_tick = ramp_speed_select_r
		? (ramp_cnt_r[5:0] == 6'(RAMP_FAST_INTERVAL - 1))
		: (ramp_cnt_r == 8'(RAMP_SLOW_INTERVAL - 1));

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			reference_as_marker_enable_r <= 1'b0;
			single_channel_r             <= 1'b0;
			marker_insert_enable_r       <= 1'b0;
			coarse_target_r              <= RST_DELAY;
			fine_r                       <= RST_DELAY;
			invert_r                     <= 1'b0;
			aperture_delay_ramp_r        <= 1'b0;
			ramp_speed_select_r          <= 1'b0;
			demux_factor_setting_r       <= RST_DEMUX;
			frame_length_setting_r       <= RST_FRAME_LEN;
		end
		else if (clk_en && wr_take)
		begin
			case (paddr)
				OFS_CLOCK_CONTROL_ONE:
				begin
					reference_as_marker_enable_r <= pwdata[BIT_REF_AS_MARKER];
					single_channel_r             <= pwdata[BIT_SINGLE_CHANNEL];
				end
				OFS_MARKER_CONTROL:
					marker_insert_enable_r <= pwdata[BIT_MARKER_INSERT];
				OFS_APERTURE_CONTROL:
				begin
					// live rewrite; conversion keeps running
					coarse_target_r       <= pwdata[POS_COARSE +: DELAY_WIDTH];
					fine_r                <= pwdata[POS_FINE +: DELAY_WIDTH];
					invert_r              <= pwdata[BIT_INVERT];
					aperture_delay_ramp_r <= pwdata[BIT_RAMP_EN];
					ramp_speed_select_r   <= pwdata[BIT_RAMP_FAST];
				end
				OFS_FRAME_CONTROL:
				begin
					demux_factor_setting_r <= pwdata[POS_DEMUX +: 4];
					frame_length_setting_r <= pwdata[POS_FRAME_LEN +: 8];
				end
				default:
					;
			endcase
		end
	end

	// reference seen flag: a new event beats a same-cycle clear
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ref_seen_r <= 1'b0;
		else if (clk_en)
		begin
			if (ref_event)
				ref_seen_r <= 1'b1;
			else if (wr_take && paddr == OFS_STATUS && pwdata[BIT_REF_SEEN])
				ref_seen_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ramp_state_r     <= RAMP_IDLE;
			applied_coarse_r <= RST_DELAY;
			ramp_cnt_r       <= '0;
		end
		else if (clk_en)
		begin
			ramp_cnt_r <= wr_aperture ? 8'h00 : ramp_cnt_r + 8'h01;
			case (ramp_state_r)
				RAMP_IDLE:
				begin
					if (!aperture_delay_ramp_r)
						applied_coarse_r <= coarse_target_r;
					else if (coarse_target_r > applied_coarse_r)
						ramp_state_r <= RAMP_UP;
					else if (coarse_target_r < applied_coarse_r)
						ramp_state_r <= RAMP_DOWN;
				end
				RAMP_UP:
				begin
					if (!aperture_delay_ramp_r)
					begin
						ramp_state_r     <= RAMP_IDLE;
						applied_coarse_r <= coarse_target_r;
					end
					else if (coarse_target_r <= applied_coarse_r)
						ramp_state_r <= RAMP_IDLE;
					else if (ramp_tick)
						applied_coarse_r <= applied_coarse_r + 8'h01;
				end
				RAMP_DOWN:
				begin
					if (!aperture_delay_ramp_r)
					begin
						ramp_state_r     <= RAMP_IDLE;
						applied_coarse_r <= coarse_target_r;
					end
					else if (coarse_target_r >= applied_coarse_r)
						ramp_state_r <= RAMP_IDLE;
					else if (ramp_tick)
						applied_coarse_r <= applied_coarse_r - 8'h01;
				end
				default:
					ramp_state_r <= RAMP_IDLE;
			endcase
		end
	end

	// delay controls to the clock path; the three act independently
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			coarse_aperture_delay    <= RST_DELAY;
			fine_aperture_delay      <= RST_DELAY;
			half_period_clock_invert <= 1'b0;
			sample_on_both_edges     <= 1'b0;
		end
		else if (clk_en)
		begin
			coarse_aperture_delay    <= applied_coarse_r;
			fine_aperture_delay      <= fine_r;
			half_period_clock_invert <= invert_r;
			sample_on_both_edges     <= single_channel_r;
		end
	end

	// frame divider and strobe generation
	logic [11:0] frame_cycles_r;
	logic [11:0] frame_cnt_r;
	logic        div_r;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			frame_cycles_r <= 12'h001;
			frame_cnt_r    <= '0;
			div_r          <= 1'b0;
		end
		else if (clk_en)
		begin
			frame_cycles_r <= ({8'h00, demux_factor_setting_r} + 12'h001)
				* {4'h0, frame_length_setting_r};
			if (ref_event)
			begin
				// deterministic restart of divider and strobe phase
				frame_cnt_r <= '0;
				div_r       <= 1'b0;
			end
			else
			begin
				div_r <= ~div_r;
				if (frame_cnt_r + 12'h001 >= frame_cycles_r)
					frame_cnt_r <= '0;
				else
					frame_cnt_r <= frame_cnt_r + 12'h001;
			end
		end
	end

	// sample and marker pipelines, stalled together by back-pressure
	logic          advance;
	logic          fifo_in_ready;
	logic [SW-1:0] pipe_a_r [PIPE];
	logic [SW-1:0] pipe_b_r [PIPE];
	logic [PIPE-1:0] pipe_v_r;
	logic [LAT-1:0]  mark_pipe_r;
	logic          marker_src;
	logic [SW-1:0] lane_a;
	logic [SW-1:0] lane_b;
	logic          strobe_now;

	assign advance      = clk_en && fifo_in_ready;
	assign sample_ready = fifo_in_ready;
	assign marker_src   = reference_as_marker_enable_r
		? mref_sync_r[SYNC_STAGES-1] : trig_sync_r[SYNC_STAGES-1];
	assign strobe_now   = (frame_cnt_r == 12'h000);

	always_ff @(posedge clk)
	begin
		if (advance)
		begin
			pipe_a_r[0] <= ch_a_sample;
			pipe_b_r[0] <= ch_b_sample;
			for (int i = 1; i < PIPE; i++)
			begin
				// samples wait through the sync depth so the marker lines up
				pipe_a_r[i] <= pipe_a_r[i-1];
				pipe_b_r[i] <= pipe_b_r[i-1];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pipe_v_r    <= '0;
			mark_pipe_r <= '0;
			trig_sync_r <= '0;
			mref_sync_r <= '0;
		end
		else if (advance)
		begin
			// marker syncs step with the samples, so a stall cannot skew the pairing
			trig_sync_r <= {trig_sync_r[SYNC_STAGES-2:0], trigger_marker_input};
			mref_sync_r <= {mref_sync_r[SYNC_STAGES-2:0], system_reference_pulse};
			pipe_v_r    <= {pipe_v_r[PIPE-2:0], sample_valid};
			mark_pipe_r <= {mark_pipe_r[LAT-2:0], marker_src};
		end
	end

	// both lanes share the marker; in single mode b is the falling-edge sample
	always_comb
	begin
		lane_a = pipe_a_r[PIPE-1];
		lane_b = pipe_b_r[PIPE-1];
		if (marker_insert_enable_r)
		begin
			lane_a = {pipe_a_r[PIPE-1][SW-1:1], mark_pipe_r[LAT-1]};
			lane_b = {pipe_b_r[PIPE-1][SW-1:1], mark_pipe_r[LAT-1]};
		end
	end

	// output fifo toward the receiver
	logic          fifo_out_valid;
	logic          fifo_pop;
	logic [FW-1:0] fifo_out_data;

	assign fifo_pop = !lvds_bus_valid || lvds_ready;

	sample_fifo #(
		.WIDTH (FW),
		.DEPTH (FD)
	) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.in_valid  (pipe_v_r[PIPE-1] && clk_en),
		.in_ready  (fifo_in_ready),
		.in_data   ({strobe_now, lane_b, lane_a}),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lvds_bus_data   <= '0;
			lvds_bus_strobe <= 1'b0;
			lvds_bus_valid  <= 1'b0;
			lvds_bus_clock  <= 1'b0;
		end
		else if (clk_en)
		begin
			lvds_bus_clock <= div_r ^ invert_r;
			if (fifo_pop)
			begin
				lvds_bus_valid  <= fifo_out_valid;
				lvds_bus_data   <= fifo_out_data[2*SW-1:0];
				lvds_bus_strobe <= fifo_out_valid && fifo_out_data[FW-1];
			end
		end
	end

	// apb slave: one wait state, read data and error from flops
	always_comb
	begin
		rd_value = 32'h0000_0000;
		case (paddr)
			OFS_CLOCK_CONTROL_ONE:
			begin
				rd_value[BIT_REF_AS_MARKER]  = reference_as_marker_enable_r;
				rd_value[BIT_SINGLE_CHANNEL] = single_channel_r;
			end
			OFS_MARKER_CONTROL:
				rd_value[BIT_MARKER_INSERT] = marker_insert_enable_r;
			OFS_APERTURE_CONTROL:
			begin
				rd_value[POS_COARSE +: DELAY_WIDTH] = coarse_target_r;
				rd_value[POS_FINE +: DELAY_WIDTH]   = fine_r;
				rd_value[BIT_INVERT]                = invert_r;
				rd_value[BIT_RAMP_EN]               = aperture_delay_ramp_r;
				rd_value[BIT_RAMP_FAST]             = ramp_speed_select_r;
			end
			OFS_FRAME_CONTROL:
			begin
				rd_value[POS_DEMUX +: 4]     = demux_factor_setting_r;
				rd_value[POS_FRAME_LEN +: 8] = frame_length_setting_r;
			end
			OFS_STATUS:
			begin
				rd_value[POS_APPLIED_COARSE +: DELAY_WIDTH] = applied_coarse_r;
				rd_value[BIT_RAMP_BUSY] = (ramp_state_r != RAMP_IDLE);
				rd_value[BIT_REF_SEEN]  = ref_seen_r;
			end
			default:
				rd_value = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			pready <= acc_first;
			if (acc_first)
			begin
				pslverr <= !addr_ok;
				prdata  <= (!pwrite && addr_ok) ? rd_value : 32'h0000_0000;
			end
			else
			begin
				pslverr <= 1'b0;
				prdata  <= 32'h0000_0000;
			end
		end
	end
endmodule : sampling_clock_timestamp_control

// File: verif/sampling_clock_timestamp_control_sva.sv
// checker for the sampling clock block: apb timing, delay controls, output hold
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module sampling_clock_sva
	import sampling_clock_pkg::*;
#(
	parameter int SW = SAMPLE_WIDTH
) (
	input wire logic          clk,
	input wire logic          reset_n,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [7:0]    paddr,
	input wire logic [31:0]   pwdata,
	input wire logic [31:0]   prdata,
	input wire logic          pready,
	input wire logic          pslverr,
	input wire logic          lvds_ready,
	input wire logic [2*SW-1:0] lvds_bus_data,
	input wire logic          lvds_bus_strobe,
	input wire logic          lvds_bus_valid,
	input wire logic          sample_on_both_edges,
	input wire logic          half_period_clock_invert,
	input wire logic [7:0]    coarse_aperture_delay,
	input wire logic [7:0]    fine_aperture_delay
);
	logic        mapped;
	logic        wr_done;
	logic        both_r;
	logic [31:0] ap_r;
	assign mapped = paddr inside {OFS_CLOCK_CONTROL_ONE, OFS_MARKER_CONTROL,
		OFS_APERTURE_CONTROL, OFS_FRAME_CONTROL, OFS_STATUS};
	assign wr_done = psel && penable && pwrite && pready && !pslverr;
	// shadows of the last accepted writes, so outputs can be tied to them
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			both_r <= 1'h0;
			ap_r <= 32'h0;
		end
		else if (wr_done && paddr == OFS_CLOCK_CONTROL_ONE)
			both_r <= pwdata[BIT_SINGLE_CHANNEL];
		else if (wr_done && paddr == OFS_APERTURE_CONTROL)
			ap_r <= pwdata;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable;
	endsequence
	a_one_wait: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_unmapped: assert property (pready && !mapped |-> pslverr)
		else $error("no error on unmapped address");
	a_ok_mapped: assert property (pready && mapped |-> !pslverr)
		else $error("error on mapped address");
	a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer cycle");
	a_both_follow: assert property (
		wr_done && paddr == OFS_CLOCK_CONTROL_ONE |=> ##[0:2] sample_on_both_edges == both_r)
		else $error("edge mode not applied");
	a_invert_follow: assert property (
		wr_done && paddr == OFS_APERTURE_CONTROL |=> ##[0:2]
		half_period_clock_invert == ap_r[BIT_INVERT])
		else $error("invert not applied");
	a_fine_follow: assert property (
		wr_done && paddr == OFS_APERTURE_CONTROL |=> ##[0:2]
		fine_aperture_delay == ap_r[POS_FINE +: 8])
		else $error("fine delay not applied");
	a_coarse_direct: assert property (
		wr_done && paddr == OFS_APERTURE_CONTROL && !pwdata[BIT_RAMP_EN] |=> ##[0:2]
		coarse_aperture_delay == ap_r[POS_COARSE +: 8])
		else $error("coarse delay not applied");
	a_output_hold: assert property (lvds_bus_valid && !lvds_ready |=> lvds_bus_valid
		&& $stable(lvds_bus_data) && $stable(lvds_bus_strobe))
		else $error("output word changed while stalled");
	a_strobe_valid: assert property (lvds_bus_strobe |-> lvds_bus_valid)
		else $error("strobe without valid word");
endmodule : sampling_clock_sva

bind sampling_clock_timestamp_control sampling_clock_sva #(.SW(SW)) checker_i (
	.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.lvds_ready(lvds_ready), .lvds_bus_data(lvds_bus_data), .lvds_bus_strobe(lvds_bus_strobe),
	.lvds_bus_valid(lvds_bus_valid), .sample_on_both_edges(sample_on_both_edges),
	.half_period_clock_invert(half_period_clock_invert),
	.coarse_aperture_delay(coarse_aperture_delay), .fine_aperture_delay(fine_aperture_delay)
);

// File: verif/lvds_receiver_model.sv
// behavioural receiver on the lvds output bus; takes words unless stalled
// assumes the bench changes stall just after a clock edge
`timescale 1ns/1ps
module lvds_receiver_model (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        stall,
	input  wire logic        lvds_bus_valid,
	input  wire logic [23:0] lvds_bus_data,
	output logic             lvds_ready,
	output logic             took,
	output logic [23:0]      word
);
	// bus clock phase is ignored, so delay shifts cannot upset capture
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lvds_ready <= 1'h0;
			took <= 1'h0;
			word <= 24'h0;
		end
		else
		begin
			lvds_ready <= !stall;
			took <= lvds_bus_valid && lvds_ready;
			if (lvds_bus_valid && lvds_ready)
				word <= lvds_bus_data;
		end
	end
endmodule : lvds_receiver_model

// File: verif/sampling_clock_timestamp_control_bench.sv
// bench for the sampling clock block: apb registers, sample stream, ramp, reference
// assumes the receiver model on the output bus and the bound checker
`timescale 1ns/1ps
module sampling_clock_timestamp_control_bench
	import sampling_clock_pkg::*;
;
	logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, er;
	logic        sv, sr, trig, refp, rdy, stb, bv, both, inv, stall, took, lck;
	logic [7:0]  paddr, coarse, fine;
	logic [31:0] pwdata, prdata, rd;
	logic [11:0] ch_a, ch_b;
	logic [23:0] bd, word;
	logic [23:0] exp_q[$];
	int          n_errors, checks_done;
	sampling_clock_timestamp_control dut (
		.clk(clk), .reset_n(reset_n), .clk_en(1'h1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_valid(sv), .sample_ready(sr), .ch_a_sample(ch_a),
		.ch_b_sample(ch_b), .trigger_marker_input(trig), .system_reference_pulse(refp),
		.lvds_ready(rdy), .lvds_bus_data(bd), .lvds_bus_strobe(stb), .lvds_bus_valid(bv),
		.lvds_bus_clock(lck), .sample_on_both_edges(both), .half_period_clock_invert(inv),
		.coarse_aperture_delay(coarse), .fine_aperture_delay(fine));
	lvds_receiver_model rx (.clk(clk), .reset_n(reset_n), .stall(stall), .lvds_bus_valid(bv),
		.lvds_bus_data(bd), .lvds_ready(rdy), .took(took), .word(word));
	initial
	begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do @(posedge clk); while (pready !== 1'h1 && ++n < 20);
		if (n >= 20)
			n_errors++;
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic send(input int n, input int cfg);
		logic m;
		logic [11:0] a, b;
		int k;
		for (int i = 0; i < n; i++)
		begin
			m = (i % 3) == 0;
			a = {4'h5, i[6:0], ~m};
			b = {4'hC, i[6:0], ~m};
			sv <= 1'h1;
			ch_a <= a;
			ch_b <= b;
			trig <= (cfg == 2) ? ~m : m;
			refp <= (cfg == 2) ? m : 1'h0;
			if (cfg == 0)
				exp_q.push_back({b, a});
			else
				exp_q.push_back({b[11:1], m, a[11:1], m});
			k = 0;
			do @(posedge clk); while (sr !== 1'h1 && ++k < 200);
			if (k >= 200)
				n_errors++;
		end
		sv <= 1'h0;
	endtask : send
	task automatic collect(input int n);
		int k;
		for (int i = 0; i < n; i++)
		begin
			k = 0;
			do @(posedge clk); while (took !== 1'h1 && ++k < 300);
			chk("lvds took", 32'h1, {31'h0, took});
			chk("lvds word", {8'h0, exp_q.pop_front()}, {8'h0, word});
		end
	endtask : collect
	task automatic step(input int gap);
		int n;
		logic [7:0] c;
		n = 0;
		c = coarse;
		while (coarse === c && n++ < 1000) @(posedge clk);
		c = coarse;
		n = 0;
		while (coarse === c && n < 1000)
		begin
			@(posedge clk);
			n++;
		end
		chk("ramp gap", gap, n);
	endtask : step
	task automatic t_regs();
		logic [7:0] ofs [5] = '{OFS_CLOCK_CONTROL_ONE, OFS_MARKER_CONTROL,
			OFS_APERTURE_CONTROL, OFS_FRAME_CONTROL, OFS_STATUS};
		logic [31:0] rst [5] = '{32'h0, 32'h0, 32'h0,
			{16'h0, RST_FRAME_LEN, 4'h0, RST_DEMUX}, 32'h0};
		for (int i = 0; i < 5; i++)
		begin
			apb(1'h0, ofs[i], 32'h0);
			chk("reset value", rst[i], rd);
			chk("mapped status", 32'h0, {31'h0, er});
		end
		apb(1'h1, 8'h14, 32'hFFFF_FFFF);
		chk("unmapped write", 32'h1, {31'h0, er});
		apb(1'h0, 8'h14, 32'h0);
		chk("unmapped read", 32'h0, rd);
	endtask : t_regs
	task automatic t_mode();
		logic c;
		apb(1'h1, OFS_CLOCK_CONTROL_ONE, 32'h2);
		c = lck;
		@(posedge clk);
		chk("bus clock toggle", {31'h0, ~c}, {31'h0, lck});
		repeat (3) @(posedge clk);
		chk("both edges", 32'h1, {31'h0, both});
		apb(1'h1, OFS_CLOCK_CONTROL_ONE, 32'h0);
		repeat (4) @(posedge clk);
		chk("rising only", 32'h0, {31'h0, both});
	endtask : t_mode
	task automatic t_stream(input int cfg);
		int k;
		exp_q.delete();
		apb(1'h1, OFS_CLOCK_CONTROL_ONE, {31'h0, cfg == 2});
		apb(1'h1, OFS_MARKER_CONTROL, {31'h0, cfg != 0});
		stall <= 1'h1;
		fork
			send(12, cfg);
			collect(12);
			begin
				k = 0;
				do @(posedge clk); while (sr !== 1'h0 && ++k < 60);
				chk("full refuses", 32'h0, {31'h0, sr});
				repeat (5) @(posedge clk);
				stall <= 1'h0;
			end
		join
		repeat (4) @(posedge clk);
		chk("drained", 32'h2, {30'h0, sr, bv});
	endtask : t_stream
	task automatic t_ramp();
		apb(1'h1, OFS_APERTURE_CONTROL, 32'h0002_0002);
		apb(1'h0, OFS_STATUS, 32'h0);
		chk("ramp busy", 32'h1, {31'h0, rd[BIT_RAMP_BUSY]});
		step(RAMP_SLOW_INTERVAL);
		apb(1'h0, OFS_STATUS, 32'h0);
		chk("ramp done", 32'h2, {23'h0, rd[8:0]});
		apb(1'h1, OFS_APERTURE_CONTROL, 32'h0006_0000);
		step(RAMP_FAST_INTERVAL);
		apb(1'h1, OFS_APERTURE_CONTROL, 32'h0001_FFFF);
		repeat (4) @(posedge clk);
		chk("direct delay", 32'h1_FFFF, {15'h0, inv, fine, coarse});
	endtask : t_ramp
	task automatic t_ref();
		int k;
		int gap;
		apb(1'h1, OFS_FRAME_CONTROL, 32'h0000_0201);
		apb(1'h1, OFS_STATUS, 32'h0000_0200);
		fork
			send(24, 0);
			begin
				k = 0;
				do @(posedge clk); while (stb !== 1'h1 && ++k < 100);
				gap = 0;
				do @(posedge clk); while (stb !== 1'h1 && ++gap < 100);
				chk("frame gap", 32'h3, gap);
			end
		join
		refp <= 1'h1;
		repeat (4) @(posedge clk);
		refp <= 1'h0;
		repeat (4) @(posedge clk);
		apb(1'h0, OFS_STATUS, 32'h0);
		chk("reference seen", 32'h1, {31'h0, rd[BIT_REF_SEEN]});
		apb(1'h1, OFS_STATUS, 32'h0000_02FF);
		apb(1'h0, OFS_STATUS, 32'h0);
		chk("seen cleared", 32'h0, {31'h0, rd[BIT_REF_SEEN]});
	endtask : t_ref
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	// watchdog: the full sequence needs about a thousand cycles
	initial
	begin
		#(25 * 20000);
		n_errors++;
		give_verdict();
	end
	initial
	begin
		{reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{sv, ch_a, ch_b, trig, refp, stall} = '0;
		n_errors = 0;
		checks_done = 0;
		repeat (8) @(posedge clk);
		reset_n <= 1'h1;
		t_regs();
		t_mode();
		t_stream(0);
		t_stream(1);
		t_stream(2);
		t_ramp();
		t_stream(1);
		t_ref();
		give_verdict();
	end
endmodule : sampling_clock_timestamp_control_bench
